// [include/gp5ds_pkg.sv]
package gp5ds_pkg;
    // register map: full byte addresses; function and drive select placed by choice
    localparam logic [23:0] GP5DS_OFS_OUTPUT_DATA = 24'hFFFFE4;
    localparam logic [23:0] GP5DS_OFS_DIRECTION = 24'hFFFFF4;
    localparam logic [23:0] GP5DS_OFS_FUNC_SELECT = 24'hFFFFF8;
    localparam logic [23:0] GP5DS_OFS_DRIVE_SELECT = 24'hFFFFFC;
    localparam int GP5DS_ADDR_W = 24;
    localparam int GP5DS_PINS = 8;
    localparam logic [7:0] GP5DS_RST_OUTPUT_DATA = 8'h00;
    localparam logic [7:0] GP5DS_RST_DIRECTION = 8'h00;
    localparam logic [7:0] GP5DS_RST_FUNC_SELECT = 8'h00;
    localparam logic [7:0] GP5DS_RST_DRIVE_SELECT = 8'h00;
    localparam logic [7:0] GP5DS_UNMAPPED_READ = 8'h00;
    localparam logic [7:0] GP5DS_RST_PIN_SYNC = 8'h00;
endpackage : gp5ds_pkg

// [rtl/gp5ds_port.sv]
// Summary of operation
// - port 3 drive bit: 0 normal drive, 1 high-current drive
// - function bit 0 gives general I/O, 1 gives peripheral function
// - general I/O pin: direction 1 output, 0 input
// - direction enables drive only on general I/O pins, one bit per pin, but picks the data read source on every pin
// - data register bit 0 drives low, 1 drives high
// - general I/O output pin is driven from its data register bit
// - data read returns stored bit where direction is 1
// - data read returns live pin level where direction is 0
`timescale 1ns/1ps
module gp5ds_port
    import gp5ds_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [23:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [7:0] o_rdata,
    input wire logic [7:0] i_pin5,
    output logic [7:0] o_pin5,
    output logic [7:0] o_pin5_oe,
    output logic [7:0] o_pin5_periph,
    input wire logic [7:0] i_periph_out,
    input wire logic [7:0] i_periph_oe,
    output logic [7:0] o_periph_in,
    output logic [7:0] o_port3_high_drive
);
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rstn;
    logic [7:0] output_data_reg, output_data_next;
    logic [7:0] direction_reg, direction_next;
    logic [7:0] func_select_reg, func_select_next;
    logic [7:0] drive_select_reg, drive_select_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_level_reg;
    logic [7:0] pin_level_next;
    logic [7:0] read_view;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rstn = rst_sync_reg;

    // pins are asynchronous: three stages, level accepted when last two agree
    always_comb begin
        pin_level_next = pin_level_reg;
        for (int i = 0; i < GP5DS_PINS; i++) begin
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                pin_level_next[i] = pin_s3_reg[i];
            end
        end
    end

    always_comb begin
        output_data_next = output_data_reg;
        direction_next = direction_reg;
        func_select_next = func_select_reg;
        drive_select_next = drive_select_reg;
        if (i_write) begin
            unique case (i_addr)
                GP5DS_OFS_OUTPUT_DATA: output_data_next = i_wdata;
                GP5DS_OFS_DIRECTION: direction_next = i_wdata;
                GP5DS_OFS_FUNC_SELECT: func_select_next = i_wdata;
                GP5DS_OFS_DRIVE_SELECT: drive_select_next = i_wdata;
                default: ;
            endcase
        end
    end

    assign read_view = (output_data_reg & direction_reg) | (pin_level_reg & ~direction_reg);

    always_comb begin
        rdata_next = GP5DS_UNMAPPED_READ;
        if (i_read) begin
            unique case (i_addr)
                GP5DS_OFS_OUTPUT_DATA: rdata_next = read_view;
                GP5DS_OFS_DIRECTION: rdata_next = direction_reg;
                GP5DS_OFS_FUNC_SELECT: rdata_next = func_select_reg;
                GP5DS_OFS_DRIVE_SELECT: rdata_next = drive_select_reg;
                default: rdata_next = GP5DS_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge rstn) begin
        if (!rstn) begin
            output_data_reg <= GP5DS_RST_OUTPUT_DATA;
            direction_reg <= GP5DS_RST_DIRECTION;
            func_select_reg <= GP5DS_RST_FUNC_SELECT;
            drive_select_reg <= GP5DS_RST_DRIVE_SELECT;
        end else begin
            output_data_reg <= output_data_next;
            direction_reg <= direction_next;
            func_select_reg <= func_select_next;
            drive_select_reg <= drive_select_next;
        end
    end

    // read data stands one cycle, then falls back to zero
    always_ff @(posedge i_clock or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= GP5DS_UNMAPPED_READ;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge i_clock or negedge rstn) begin
        if (!rstn) begin
            pin_s1_reg <= GP5DS_RST_PIN_SYNC;
            pin_s2_reg <= GP5DS_RST_PIN_SYNC;
            pin_s3_reg <= GP5DS_RST_PIN_SYNC;
            pin_level_reg <= GP5DS_RST_PIN_SYNC;
        end else begin
            pin_s1_reg <= i_pin5;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_level_reg <= pin_level_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_port3_high_drive = drive_select_reg;

    genvar g;
    generate
        for (g = 0; g < GP5DS_PINS; g++) begin : g_pin
            always_comb begin
                if (func_select_reg[g]) begin
                    o_pin5[g] = i_periph_out[g];
                    o_pin5_oe[g] = i_periph_oe[g];
                end else begin
                    o_pin5[g] = output_data_reg[g];
                    o_pin5_oe[g] = direction_reg[g];
                end
            end
        end
    endgenerate
    assign o_pin5_periph = func_select_reg;
    // peripheral sees the filtered level only when it owns the pin
    assign o_periph_in = pin_level_reg & func_select_reg;

    property p_gpio_out;
        @(posedge i_clock) disable iff (!rstn)
        (func_select_reg == 8'h00) |-> (o_pin5_oe == direction_reg && o_pin5 == output_data_reg);
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("gpio drive mismatch");
    property p_periph_own;
        @(posedge i_clock) disable iff (!rstn)
        1'b1 |-> ((o_pin5_oe & func_select_reg) == (i_periph_oe & func_select_reg));
    endproperty
    a_periph_own: assert property (p_periph_own) else $error("periph ownership");
    property p_dir_only_gpio;
        @(posedge i_clock) disable iff (!rstn)
        1'b1 |-> ((o_pin5_oe & ~func_select_reg) == (direction_reg & ~func_select_reg));
    endproperty
    a_dir_only_gpio: assert property (p_dir_only_gpio) else $error("direction leak");
    property p_in_no_drive;
        @(posedge i_clock) disable iff (!rstn)
        1'b1 |-> ((o_pin5_oe & ~func_select_reg & ~direction_reg) == 8'h00);
    endproperty
    a_in_no_drive: assert property (p_in_no_drive) else $error("input driven");
    property p_level;
        @(posedge i_clock) disable iff (!rstn)
        ((o_pin5 & ~func_select_reg & direction_reg) ==
            (output_data_reg & ~func_select_reg & direction_reg));
    endproperty
    a_level: assert property (p_level) else $error("wrong level");
    property p_read_out;
        @(posedge i_clock) disable iff (!rstn)
        (i_read && i_addr == GP5DS_OFS_OUTPUT_DATA) |=>
            ((o_rdata & $past(direction_reg)) == ($past(output_data_reg) & $past(direction_reg)));
    endproperty
    a_read_out: assert property (p_read_out) else $error("stored readback");
    property p_read_in;
        @(posedge i_clock) disable iff (!rstn)
        (i_read && i_addr == GP5DS_OFS_OUTPUT_DATA) |=>
            ((o_rdata & ~$past(direction_reg)) == ($past(pin_level_reg) & ~$past(direction_reg)));
    endproperty
    a_read_in: assert property (p_read_in) else $error("live readback");
    property p_write_dir;
        @(posedge i_clock) disable iff (!rstn)
        (i_write && i_addr == GP5DS_OFS_DIRECTION) |=> (direction_reg == $past(i_wdata));
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("direction write");
    property p_drive;
        @(posedge i_clock) disable iff (!rstn)
        (i_write && i_addr == GP5DS_OFS_DRIVE_SELECT) |=> (o_port3_high_drive == $past(i_wdata));
    endproperty
    a_drive: assert property (p_drive) else $error("drive select");

    // register bus contract checks
    logic addr_hit;
    assign addr_hit = (i_addr == GP5DS_OFS_OUTPUT_DATA) || (i_addr == GP5DS_OFS_DIRECTION)
        || (i_addr == GP5DS_OFS_FUNC_SELECT) || (i_addr == GP5DS_OFS_DRIVE_SELECT);
    property p_write_data;
        @(posedge i_clock) disable iff (!rstn)
        (i_write && i_addr == GP5DS_OFS_OUTPUT_DATA) |=> (output_data_reg == $past(i_wdata));
    endproperty
    a_write_data: assert property (p_write_data) else $error("data write");
    property p_write_func;
        @(posedge i_clock) disable iff (!rstn)
        (i_write && i_addr == GP5DS_OFS_FUNC_SELECT) |=> (o_pin5_periph == $past(i_wdata));
    endproperty
    a_write_func: assert property (p_write_func) else $error("function write");
    property p_read_dir;
        @(posedge i_clock) disable iff (!rstn)
        (i_read && i_addr == GP5DS_OFS_DIRECTION) |=> (o_rdata == $past(direction_reg));
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("direction read");
    property p_read_func;
        @(posedge i_clock) disable iff (!rstn)
        (i_read && i_addr == GP5DS_OFS_FUNC_SELECT) |=> (o_rdata == $past(func_select_reg));
    endproperty
    a_read_func: assert property (p_read_func) else $error("function read");
    property p_read_drive;
        @(posedge i_clock) disable iff (!rstn)
        (i_read && i_addr == GP5DS_OFS_DRIVE_SELECT) |=> (o_rdata == $past(drive_select_reg));
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("drive read");
    property p_rdata_idle;
        @(posedge i_clock) disable iff (!rstn)
        !i_read |=> (o_rdata == GP5DS_UNMAPPED_READ);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_read_unmapped;
        @(posedge i_clock) disable iff (!rstn)
        (i_read && !addr_hit) |=> (o_rdata == GP5DS_UNMAPPED_READ);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read");
    property p_write_unmapped;
        @(posedge i_clock) disable iff (!rstn)
        (i_write && !addr_hit) |=> ($stable(output_data_reg) && $stable(direction_reg)
            && $stable(func_select_reg) && $stable(drive_select_reg));
    endproperty
    a_write_unmapped: assert property (p_write_unmapped) else $error("unmapped write");
    property p_hold_dir;
        @(posedge i_clock) disable iff (!rstn)
        !(i_write && i_addr == GP5DS_OFS_DIRECTION) |=> $stable(direction_reg);
    endproperty
    a_hold_dir: assert property (p_hold_dir) else $error("direction changed");
    property p_hold_data;
        @(posedge i_clock) disable iff (!rstn)
        !(i_write && i_addr == GP5DS_OFS_OUTPUT_DATA) |=> $stable(output_data_reg);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("data changed");
    property p_hold_func;
        @(posedge i_clock) disable iff (!rstn)
        !(i_write && i_addr == GP5DS_OFS_FUNC_SELECT) |=> $stable(func_select_reg);
    endproperty
    a_hold_func: assert property (p_hold_func) else $error("function changed");
    property p_hold_drive;
        @(posedge i_clock) disable iff (!rstn)
        !(i_write && i_addr == GP5DS_OFS_DRIVE_SELECT) |=> $stable(drive_select_reg);
    endproperty
    a_hold_drive: assert property (p_hold_drive) else $error("drive changed");
    property p_reset_regs;
        @(posedge i_clock) disable iff (!rstn)
        $rose(rstn) |-> (output_data_reg == GP5DS_RST_OUTPUT_DATA
            && direction_reg == GP5DS_RST_DIRECTION && func_select_reg == GP5DS_RST_FUNC_SELECT
            && drive_select_reg == GP5DS_RST_DRIVE_SELECT);
    endproperty
    a_reset_regs: assert property (p_reset_regs) else $error("reset values");

    // pin and ownership checks
    property p_periph_in;
        @(posedge i_clock) disable iff (!rstn)
        ((o_periph_in & ~func_select_reg) == 8'h00);
    endproperty
    a_periph_in: assert property (p_periph_in) else $error("periph input leak");
    property p_periph_level;
        @(posedge i_clock) disable iff (!rstn)
        ((o_pin5 & func_select_reg) == (i_periph_out & func_select_reg));
    endproperty
    a_periph_level: assert property (p_periph_level) else $error("periph level");
    property p_pin_accept;
        @(posedge i_clock) disable iff (!rstn)
        (pin_s2_reg == pin_s3_reg) |=> (pin_level_reg == $past(pin_s3_reg));
    endproperty
    a_pin_accept: assert property (p_pin_accept) else $error("pin level not taken");
    property p_pin_hold;
        @(posedge i_clock) disable iff (!rstn)
        1'b1 |=> (((pin_level_reg ^ $past(pin_level_reg))
            & ($past(pin_s2_reg) ^ $past(pin_s3_reg))) == 8'h00);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("unsettled pin taken");

    c_out: cover property (@(posedge i_clock) disable iff (!rstn) o_pin5_oe == 8'hFF);
    c_periph: cover property (@(posedge i_clock) disable iff (!rstn) func_select_reg != 8'h00);
    c_rd: cover property (@(posedge i_clock) disable iff (!rstn)
        i_read && i_addr == GP5DS_OFS_OUTPUT_DATA && direction_reg == 8'hF0);
    c_stored: cover property (@(posedge i_clock) disable iff (!rstn)
        i_read && i_addr == GP5DS_OFS_OUTPUT_DATA && (direction_reg & func_select_reg) != 8'h00);
    c_high_drive: cover property (@(posedge i_clock) disable iff (!rstn)
        o_port3_high_drive != 8'h00);
endmodule : gp5ds_port

// [verif/gp5ds_pad_model.sv]
`timescale 1ns/1ps
module gp5ds_pad_model (
    input wire logic [7:0] i_pin_out,
    input wire logic [7:0] i_pin_oe,
    input wire logic [7:0] i_ext_level,
    output logic [7:0] o_pin_level
);
    // released pins follow the outside circuit, never the last driven value
    assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
endmodule : gp5ds_pad_model

// [verif/test_gpio_port5_with_drive_select.sv]
`timescale 1ns/1ps
module test_gpio_port5_with_drive_select;
    import gp5ds_pkg::*;
    logic clk, rstn, wr, rd;
    logic [23:0] addr;
    logic [7:0] wdata, rdata, pin, pout, poe, pper, pio, pie, pin_in, hdrv, ext;
    int err_count = 0;
    int checked = 0;
    gp5ds_port gp5ds_port_inst (.i_clock(clk), .i_resetn(rstn), .i_addr(addr),
        .i_wdata(wdata), .i_write(wr), .i_read(rd), .o_rdata(rdata), .i_pin5(pin),
        .o_pin5(pout), .o_pin5_oe(poe), .o_pin5_periph(pper), .i_periph_out(pio),
        .i_periph_oe(pie), .o_periph_in(pin_in), .o_port3_high_drive(hdrv));
    gp5ds_pad_model gp5ds_pad_model_inst (.i_pin_out(pout), .i_pin_oe(poe),
        .i_ext_level(ext), .o_pin_level(pin));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [23:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [23:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask : rd_reg
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic t_reset_values();
        rd_reg(GP5DS_OFS_OUTPUT_DATA, 8'h3C, "data_live");
        rd_reg(GP5DS_OFS_DIRECTION, GP5DS_RST_DIRECTION, "dir_rst");
        rd_reg(GP5DS_OFS_FUNC_SELECT, GP5DS_RST_FUNC_SELECT, "func_rst");
        rd_reg(GP5DS_OFS_DRIVE_SELECT, GP5DS_RST_DRIVE_SELECT, "drv_rst");
        wr_reg(24'hFFFF00, 8'hFF);
        rd_reg(24'hFFFF00, GP5DS_UNMAPPED_READ, "unmapped");
        check("oe_rst", poe, 8'h00);
        check("drv_unmapped", hdrv, GP5DS_RST_DRIVE_SELECT);
    endtask : t_reset_values
    task automatic t_direction_data();
        wr_reg(GP5DS_OFS_OUTPUT_DATA, 8'hA5);
        check("oe_in", poe, 8'h00);
        wr_reg(GP5DS_OFS_DIRECTION, 8'hF0);
        check("oe_out", poe, 8'hF0);
        check("pin_out", pout & 8'hF0, 8'hA0);
        repeat (5) @(posedge clk);
        rd_reg(GP5DS_OFS_OUTPUT_DATA, 8'hAC, "data_mix");
        rd_reg(GP5DS_OFS_DIRECTION, 8'hF0, "dir_rb");
    endtask : t_direction_data
    task automatic t_function();
        wr_reg(GP5DS_OFS_FUNC_SELECT, 8'h0F);
        check("periph_own", pper, 8'h0F);
        check("oe_mix", poe, 8'hF5);
        check("pin_mix", pout & poe, 8'hA0);
        repeat (5) @(posedge clk);
        #1;
        check("periph_in", pin_in, 8'h08);
        rd_reg(GP5DS_OFS_OUTPUT_DATA, 8'hA8, "data_per");
    endtask : t_function
    task automatic t_stored_read();
        wr_reg(GP5DS_OFS_DIRECTION, 8'hFF);
        check("oe_per_dir", poe, 8'hF5);
        repeat (5) @(posedge clk);
        rd_reg(GP5DS_OFS_OUTPUT_DATA, 8'hA5, "data_stored");
        wr_reg(GP5DS_OFS_FUNC_SELECT, 8'h00);
        check("oe_all", poe, 8'hFF);
        check("pin_all", pout, 8'hA5);
        check("periph_none", pin_in, 8'h00);
    endtask : t_stored_read
    task automatic t_drive();
        wr_reg(GP5DS_OFS_DRIVE_SELECT, 8'h81);
        check("high_drv", hdrv, 8'h81);
        rd_reg(GP5DS_OFS_DRIVE_SELECT, 8'h81, "drv_rb");
    endtask : t_drive
    task automatic t_mid_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check("oe_mid_rst", poe, 8'h00);
        check("drv_mid_rst", hdrv, GP5DS_RST_DRIVE_SELECT);
        rd_reg(GP5DS_OFS_DIRECTION, GP5DS_RST_DIRECTION, "dir_mid_rst");
        rd_reg(GP5DS_OFS_OUTPUT_DATA, 8'h3C, "data_mid_rst");
    endtask : t_mid_reset
    initial begin
        rstn = 1'b0;
        {wr, rd} = 2'b00;
        addr = 24'h000000;
        wdata = 8'h00;
        pio = 8'h0A;
        pie = 8'h05;
        ext = 8'h3C;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset_values();
        t_direction_data();
        t_function();
        t_stored_read();
        t_drive();
        t_mid_reset();
        report_and_stop();
    end
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule : test_gpio_port5_with_drive_select
